// ---- srs_pkg.sv ----
`default_nettype none
package srs_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] SRS_ADDR_WAIT_SEL = 8'h00;
  localparam logic [7:0] SRS_ADDR_CTRL = 8'h04;
  localparam logic [7:0] SRS_ADDR_STATUS = 8'h08;
  localparam logic [7:0] SRS_ADDR_CORE = 8'h0C;
  localparam logic [7:0] SRS_ADDR_BANK = 8'h10;
  localparam logic [3:0] SRS_WAIT_SEL_RST = 4'h0;
  localparam int SRS_CTRL_IME_BIT = 0;
  localparam int SRS_PCC_STOP_BIT = 3;
  localparam int SRS_PCC_HALT_BIT = 2;
  localparam int SRS_RBE_BIT = 6;
  localparam int SRS_MBE_BIT = 7;
  localparam int SRS_PC_HI_W = 6;
  // ****************************************************************
  // wait codes (low three bits of the wait select)
  // ****************************************************************
  localparam logic [2:0] SRS_WS_20A = 3'h0;
  localparam logic [2:0] SRS_WS_20B = 3'h1;
  localparam logic [2:0] SRS_WS_17 = 3'h3;
  localparam logic [2:0] SRS_WS_15 = 3'h5;
  localparam logic [2:0] SRS_WS_13 = 3'h7;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int SRS_CLK_PERIOD_NS = 100;
  localparam int SRS_RESET_WAIT_NS = 31300000;
  localparam int SRS_RESET_WAIT_CYC = (SRS_RESET_WAIT_NS + SRS_CLK_PERIOD_NS - 1) / SRS_CLK_PERIOD_NS;
  localparam int SRS_WAKE_INSTR = 2;
  localparam logic [13:0] SRS_PMEM_HI = 14'h0000;
  localparam logic [13:0] SRS_PMEM_LO = 14'h0001;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [7:0] {
    SRS_RST_WAIT = 8'h01,
    SRS_FETCH_HI = 8'h02,
    SRS_FETCH_LO = 8'h04,
    SRS_RUN = 8'h08,
    SRS_HALT = 8'h10,
    SRS_STOP_OSC = 8'h20,
    SRS_STOP_WAIT = 8'h40,
    SRS_WAKE_RUN = 8'h80
  } srs_state_t;
  typedef struct packed {
    logic [13:0] pc;
    logic register_bank_enable;
    logic memory_bank_enable;
    logic [2:0] skip_flags;
    logic [1:0] irq_status_bits;
    logic [3:0] memory_bank_select;
    logic [3:0] register_bank_select;
  } srs_core_t;
endpackage
`default_nettype wire

// ---- srs_gpr_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// general register store: no reset, contents survive any reset
module srs_gpr_mem #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // clock
  input wire logic pclk,
  // access
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata_ff
);
  logic [WIDTH-1:0] mem [DEPTH];

  initial begin
    if (DEPTH > (1 << AW)) $error("srs_gpr_mem: DEPTH exceeds address range");
  end

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge pclk) begin
    rdata_ff <= mem[addr];
  end
endmodule
`default_nettype wire

// ---- srs_sequencer.sv ----
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Leave STOP or HALT on reset input or an enabled interrupt request.
// - STOP entry sets clock control bit 3; HALT entry sets bit 2.
// - STOP settling wait counts only after oscillation restarts, start-up added.
// - Interrupt STOP release takes wait length from wait-select low three bits.
// - Reset release from standby runs the ordinary reset sequence.
// - Interrupt wake with master enable 0 resumes in line, no vector.
// - In that case the waking request flag is kept set.
// - Interrupt wake with master enable 1 runs two instructions, then vectors.
// - Watch-timer or testable-input wake never vectors; resume in line, keep flag.
// - After reset release hold execution about 31.3 ms before first fetch.
// - Reset loads PC 13:8 from word 0 low six bits, 7:0 from word 1.
// - Reset copies word 0 bit 6 to register bank enable, bit 7 to memory.
// - Any reset clears the three skip flags.
// - Any reset clears both interrupt status bits.
// - Reset in standby keeps general registers; in operation they are undefined.
// - Any reset clears memory and register bank select.
module srs_sequencer
  import srs_pkg::*;
#(
  parameter int NIRQ = 4,
  parameter int CNT_W = 21,
  parameter int RESET_WAIT = SRS_RESET_WAIT_CYC,
  parameter int WAIT_20 = 1 << 20,
  parameter int WAIT_17 = 1 << 17,
  parameter int WAIT_15 = 1 << 15,
  parameter int WAIT_13 = 1 << 13
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  // pins
  input wire logic ext_reset_n,
  input wire logic osc_running,
  output logic osc_stop_ff,
  // interrupt sources
  input wire logic [NIRQ-1:0] irq_req,
  input wire logic [NIRQ-1:0] irq_en,
  input wire logic watch_timer_request,
  input wire logic watch_timer_en,
  input wire logic testable_input_request,
  input wire logic testable_input_en,
  output logic irq_flag_hold_ff,
  // cpu
  input wire logic stop_exec,
  input wire logic halt_exec,
  input wire logic instr_done,
  output logic cpu_run_ff,
  output logic vector_take_ff,
  output logic resume_inline_ff,
  output logic [3:0] processor_clock_control_ff,
  output srs_core_t core_ff,
  input wire logic gpr_wr,
  input wire logic [2:0] gpr_addr,
  input wire logic [3:0] gpr_wdata,
  output logic [3:0] gpr_rdata_ff,
  output logic gpr_valid_ff,
  // program memory
  output logic pmem_rd_ff,
  output logic [13:0] pmem_addr_ff,
  input wire logic [7:0] pmem_rdata
);
  // ****************************************************************
  // checks and declarations
  // ****************************************************************
  initial begin
    if (CNT_W < 2 || CNT_W > 31) $error("srs_sequencer: CNT_W out of range");
    if (WAIT_20 >= (1 << CNT_W) || RESET_WAIT >= (1 << CNT_W)) $error("srs_sequencer: CNT_W too small");
    if (WAIT_13 < 1 || RESET_WAIT < 1) $error("srs_sequencer: wait counts must be positive");
  end

  srs_state_t state_ff;
  logic [1:0] rst_sync_ff, osc_sync_ff;
  logic [3:0] standby_wait_select_ff;
  logic master_irq_enable_ff;
  logic [CNT_W-1:0] wait_cnt_ff, wait_target;
  logic fetch_ph_ff, vect_pend_ff, instr_cnt_ff;
  logic rst_pin, osc_ok, wake, vect_wake, ws_stop;
  logic apb_acc, apb_wr;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_sync_ff <= 2'h0;
      osc_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], ext_reset_n};
      osc_sync_ff <= osc_stop_ff ? 2'h0 : {osc_sync_ff[0], osc_running};
    end
  end
  assign rst_pin = !rst_sync_ff[1];
  assign osc_ok = osc_sync_ff[1];

  // ****************************************************************
  // wake decode
  // ****************************************************************
  assign vect_wake = |(irq_req & irq_en);
  assign wake = vect_wake || (watch_timer_request && watch_timer_en) ||
                (testable_input_request && testable_input_en);

  always_comb begin
    unique case (standby_wait_select_ff[2:0])
      SRS_WS_17: wait_target = CNT_W'(WAIT_17 - 1);
      SRS_WS_15: wait_target = CNT_W'(WAIT_15 - 1);
      SRS_WS_13: wait_target = CNT_W'(WAIT_13 - 1);
      default: wait_target = CNT_W'(WAIT_20 - 1);
    endcase
  end
  assign ws_stop = (state_ff == SRS_STOP_OSC) || (state_ff == SRS_STOP_WAIT);

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= SRS_RST_WAIT;
      wait_cnt_ff <= '0;
      fetch_ph_ff <= 1'b0;
      vect_pend_ff <= 1'b0;
      instr_cnt_ff <= 1'b0;
      processor_clock_control_ff <= 4'h0;
      osc_stop_ff <= 1'b0;
      cpu_run_ff <= 1'b0;
      vector_take_ff <= 1'b0;
      resume_inline_ff <= 1'b0;
      irq_flag_hold_ff <= 1'b0;
      pmem_rd_ff <= 1'b0;
      pmem_addr_ff <= SRS_PMEM_HI;
    end else begin
      vector_take_ff <= 1'b0;
      resume_inline_ff <= 1'b0;
      pmem_rd_ff <= 1'b0;
      if (rst_pin) begin
        state_ff <= SRS_RST_WAIT;
        wait_cnt_ff <= '0;
        processor_clock_control_ff <= 4'h0;
        osc_stop_ff <= 1'b0;
        cpu_run_ff <= 1'b0;
        irq_flag_hold_ff <= 1'b0;
      end else begin
        unique case (state_ff)
          SRS_RST_WAIT: begin
            if (osc_ok) begin
              if (wait_cnt_ff == CNT_W'(RESET_WAIT - 1)) begin
                state_ff <= SRS_FETCH_HI;
                wait_cnt_ff <= '0;
                pmem_rd_ff <= 1'b1;
                pmem_addr_ff <= SRS_PMEM_HI;
                fetch_ph_ff <= 1'b0;
              end else begin
                wait_cnt_ff <= wait_cnt_ff + CNT_W'(1);
              end
            end
          end
          SRS_FETCH_HI: begin
            fetch_ph_ff <= !fetch_ph_ff;
            if (fetch_ph_ff) begin
              state_ff <= SRS_FETCH_LO;
              pmem_rd_ff <= 1'b1;
              pmem_addr_ff <= SRS_PMEM_LO;
            end
          end
          SRS_FETCH_LO: begin
            fetch_ph_ff <= !fetch_ph_ff;
            if (fetch_ph_ff) begin
              state_ff <= SRS_RUN;
              cpu_run_ff <= 1'b1;
            end
          end
          SRS_RUN: begin
            irq_flag_hold_ff <= 1'b0;
            if (stop_exec) begin
              processor_clock_control_ff[SRS_PCC_STOP_BIT] <= 1'b1;
              state_ff <= SRS_STOP_OSC;
              osc_stop_ff <= 1'b1;
              cpu_run_ff <= 1'b0;
            end else if (halt_exec) begin
              processor_clock_control_ff[SRS_PCC_HALT_BIT] <= 1'b1;
              state_ff <= SRS_HALT;
              cpu_run_ff <= 1'b0;
            end
          end
          SRS_HALT: begin
            if (wake) begin
              processor_clock_control_ff[SRS_PCC_HALT_BIT] <= 1'b0;
              cpu_run_ff <= 1'b1;
              instr_cnt_ff <= 1'b0;
              if (master_irq_enable_ff && vect_wake) begin
                state_ff <= SRS_WAKE_RUN;
              end else begin
                state_ff <= SRS_RUN;
                resume_inline_ff <= 1'b1;
                irq_flag_hold_ff <= 1'b1;
              end
            end
          end
          SRS_STOP_OSC: begin
            if (wake) begin
              state_ff <= SRS_STOP_WAIT;
              osc_stop_ff <= 1'b0;
              wait_cnt_ff <= '0;
              vect_pend_ff <= master_irq_enable_ff && vect_wake;
            end
          end
          SRS_STOP_WAIT: begin
            if (osc_ok) begin
              if (wait_cnt_ff == wait_target) begin
                processor_clock_control_ff[SRS_PCC_STOP_BIT] <= 1'b0;
                cpu_run_ff <= 1'b1;
                instr_cnt_ff <= 1'b0;
                wait_cnt_ff <= '0;
                if (vect_pend_ff) begin
                  state_ff <= SRS_WAKE_RUN;
                end else begin
                  state_ff <= SRS_RUN;
                  resume_inline_ff <= 1'b1;
                  irq_flag_hold_ff <= 1'b1;
                end
              end else begin
                wait_cnt_ff <= wait_cnt_ff + CNT_W'(1);
              end
            end
          end
          SRS_WAKE_RUN: begin
            if (instr_done) begin
              instr_cnt_ff <= 1'b1;
              if (instr_cnt_ff) begin
                state_ff <= SRS_RUN;
                vector_take_ff <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // core state load and clear
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ff <= '0;
    end else if (rst_pin) begin
      core_ff.skip_flags <= 3'h0;
      core_ff.irq_status_bits <= 2'h0;
      core_ff.memory_bank_select <= 4'h0;
      core_ff.register_bank_select <= 4'h0;
    end else if (fetch_ph_ff && state_ff == SRS_FETCH_HI) begin
      core_ff.pc[13:8] <= pmem_rdata[SRS_PC_HI_W-1:0];
      core_ff.register_bank_enable <= pmem_rdata[SRS_RBE_BIT];
      core_ff.memory_bank_enable <= pmem_rdata[SRS_MBE_BIT];
    end else if (fetch_ph_ff && state_ff == SRS_FETCH_LO) begin
      core_ff.pc[7:0] <= pmem_rdata;
    end else if (apb_wr && paddr == SRS_ADDR_BANK) begin
      core_ff.skip_flags <= pwdata[2:0];
      core_ff.irq_status_bits <= pwdata[4:3];
      core_ff.memory_bank_select <= pwdata[11:8];
      core_ff.register_bank_select <= pwdata[15:12];
    end
  end

  // ****************************************************************
  // general registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpr_valid_ff <= 1'b0;
    end else if (rst_pin) begin
      if (state_ff == SRS_RUN || state_ff == SRS_WAKE_RUN) begin
        gpr_valid_ff <= 1'b0;
      end
    end else if (gpr_wr && cpu_run_ff) begin
      gpr_valid_ff <= 1'b1;
    end
  end

  srs_gpr_mem #(.WIDTH(4), .DEPTH(8), .AW(3)) u_gpr (
    .pclk(pclk),
    .wr_en(gpr_wr && cpu_run_ff && !rst_pin),
    .addr(gpr_addr),
    .wdata(gpr_wdata),
    .rdata_ff(gpr_rdata_ff)
  );

  // ****************************************************************
  // apb slave, one wait state
  // ****************************************************************
  assign apb_acc = psel && penable && pready_ff;
  assign apb_wr = apb_acc && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_wait_select_ff <= SRS_WAIT_SEL_RST;
      master_irq_enable_ff <= 1'b0;
    end else if (rst_pin) begin
      standby_wait_select_ff <= SRS_WAIT_SEL_RST;
      master_irq_enable_ff <= 1'b0;
    end else if (apb_wr && paddr == SRS_ADDR_WAIT_SEL) begin
      standby_wait_select_ff <= pwdata[3:0];
    end else if (apb_wr && paddr == SRS_ADDR_CTRL) begin
      master_irq_enable_ff <= pwdata[SRS_CTRL_IME_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      if (psel && penable && !pready_ff) begin
        unique case (paddr)
          SRS_ADDR_WAIT_SEL: prdata_ff <= {28'h0, standby_wait_select_ff};
          SRS_ADDR_CTRL: prdata_ff <= {31'h0, master_irq_enable_ff};
          SRS_ADDR_STATUS: prdata_ff <= {16'h0, state_ff, 3'h0, osc_ok,
                                         processor_clock_control_ff};
          SRS_ADDR_CORE: prdata_ff <= {3'h0, core_ff};
          SRS_ADDR_BANK: prdata_ff <= {16'h0, core_ff.register_bank_select,
                                       core_ff.memory_bank_select, 3'h0,
                                       core_ff.irq_status_bits, core_ff.skip_flags};
          default: pslverr_ff <= 1'b1;
        endcase
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence halt_wake_vec_s;
    state_ff == SRS_HALT && !rst_pin && wake && master_irq_enable_ff && vect_wake;
  endsequence
  sequence two_instr_s;
    (state_ff == SRS_WAKE_RUN && instr_done && instr_cnt_ff && !rst_pin);
  endsequence

  stop_sets_pcc_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == SRS_RUN && !rst_pin && stop_exec |=>
    processor_clock_control_ff[SRS_PCC_STOP_BIT] && state_ff == SRS_STOP_OSC)
    else $error("stop entry did not set clock control bit");
  halt_sets_pcc_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == SRS_RUN && !rst_pin && !stop_exec && halt_exec |=>
    processor_clock_control_ff[SRS_PCC_HALT_BIT] && state_ff == SRS_HALT)
    else $error("halt entry did not set clock control bit");
  wait_needs_osc_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == SRS_STOP_WAIT && !osc_ok && !rst_pin |=> $stable(wait_cnt_ff))
    else $error("settling count advanced without oscillation");
  wait_code13_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == SRS_STOP_WAIT && standby_wait_select_ff[2:0] == SRS_WS_13 &&
    osc_ok && wait_cnt_ff < CNT_W'(WAIT_13 - 1) && !rst_pin |=> state_ff == SRS_STOP_WAIT)
    else $error("stop wait ended early");
  reset_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    rst_pin |=> core_ff.skip_flags == 3'h0 && core_ff.irq_status_bits == 2'h0 &&
    core_ff.memory_bank_select == 4'h0 && core_ff.register_bank_select == 4'h0)
    else $error("reset did not clear core flags");
  reset_holds_cpu_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == SRS_RST_WAIT |-> !cpu_run_ff && !pmem_rd_ff)
    else $error("cpu ran during reset wait");
  inline_resume_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == SRS_HALT && !rst_pin && wake && !(master_irq_enable_ff && vect_wake) |=>
    resume_inline_ff && irq_flag_hold_ff && state_ff == SRS_RUN)
    else $error("inline resume missing");
  no_vec_wt_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == SRS_HALT && !rst_pin && !vect_wake && wake |=> !vector_take_ff [*4])
    else $error("vector taken for non-vectoring source");
  vec_after_two_a: assert property (@(posedge pclk) disable iff (!presetn)
    halt_wake_vec_s |=> state_ff == SRS_WAKE_RUN && !vector_take_ff)
    else $error("vectored wake did not run instructions first");
  vec_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    two_instr_s |=> vector_take_ff ##1 !vector_take_ff)
    else $error("vector not taken after second instruction");
  pc_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == SRS_FETCH_LO && fetch_ph_ff && !rst_pin |=>
    core_ff.pc[7:0] == $past(pmem_rdata) && state_ff == SRS_RUN)
    else $error("pc low byte not loaded");
  bank_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == SRS_FETCH_HI && fetch_ph_ff && !rst_pin |=>
    core_ff.register_bank_enable == $past(pmem_rdata[SRS_RBE_BIT]) &&
    core_ff.memory_bank_enable == $past(pmem_rdata[SRS_MBE_BIT]))
    else $error("bank enables not loaded");
  gpr_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    rst_pin && (state_ff == SRS_HALT || ws_stop) |=> $stable(gpr_valid_ff))
    else $error("standby reset disturbed general registers");
endmodule
`default_nettype wire

// ---- srs_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// program memory and main oscillator beside the sequencer
// ****************************************************************
module srs_far_model #(
  parameter logic [7:0] WORD0 = 8'hA5,
  parameter logic [7:0] WORD1 = 8'h3C,
  parameter int OSC_START = 5
) (
  // clock
  input wire logic pclk,
  // program memory
  input wire logic pmem_rd_ff,
  input wire logic [13:0] pmem_addr_ff,
  output var logic [7:0] pmem_rdata,
  // oscillator
  input wire logic osc_stop_ff,
  output var logic osc_running
);
  int osc_cnt = 0;
  initial pmem_rdata = 8'h00;
  initial osc_running = 1'b1;
  // word valid one cycle after the strobe, churning otherwise
  always @(posedge pclk) begin
    if (pmem_rd_ff) begin
      pmem_rdata <= (pmem_addr_ff == 14'h0000) ? WORD0 : WORD1;
    end else begin
      pmem_rdata <= ~pmem_rdata;
    end
  end
  // start-up delay before the clock comes back
  always @(posedge pclk) begin
    if (osc_stop_ff) begin
      osc_running <= 1'b0;
      osc_cnt <= 0;
    end else if (!osc_running) begin
      osc_cnt <= osc_cnt + 1;
      if (osc_cnt == OSC_START) osc_running <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- standby_release_reset_sequencer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module standby_release_reset_sequencer_tb_top;
  import srs_pkg::*;
  localparam logic [7:0] W0 = 8'hA5;
  localparam logic [7:0] W1 = 8'h3C;
  logic pclk, presetn, psel, penable, pwrite, ext_reset_n, osc_running, osc_stop_ff;
  logic [7:0] paddr, pmem_rdata;
  logic [31:0] pwdata, prdata_ff, r;
  logic pready_ff, pslverr_ff, irq_flag_hold_ff, cpu_run_ff, vector_take_ff;
  logic resume_inline_ff, gpr_valid_ff, pmem_rd_ff, wt_req, wt_en, ti_req, ti_en;
  logic [3:0] irq_req, irq_en, processor_clock_control, gpr_rdata_ff, cpu_pulse, gpr_d;
  logic [2:0] gpr_a;
  logic [13:0] pmem_addr_ff;
  logic [33:0] cur;
  srs_core_t core_ff;
  logic [33:0] exp_q[$];
  int bad_count = 0, samples_checked = 0, seed = 65458, n, vec_cnt = 0, w;
  int waits[5] = '{16, 16, 12, 8, 4};
  logic [2:0] codes[5] = '{SRS_WS_20A, SRS_WS_20B, SRS_WS_17, SRS_WS_15, SRS_WS_13};
  wire logic [4:0] ev = {pready_ff, osc_running, vector_take_ff, resume_inline_ff, cpu_run_ff};
  srs_sequencer #(.RESET_WAIT(8), .WAIT_20(16), .WAIT_17(12), .WAIT_15(8), .WAIT_13(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff), .ext_reset_n(ext_reset_n), .osc_running(osc_running),
    .osc_stop_ff(osc_stop_ff), .irq_req(irq_req), .irq_en(irq_en),
    .watch_timer_request(wt_req), .watch_timer_en(wt_en), .testable_input_request(ti_req),
    .testable_input_en(ti_en), .irq_flag_hold_ff(irq_flag_hold_ff),
    .stop_exec(cpu_pulse[0]), .halt_exec(cpu_pulse[1]), .instr_done(cpu_pulse[2]),
    .cpu_run_ff(cpu_run_ff), .vector_take_ff(vector_take_ff),
    .resume_inline_ff(resume_inline_ff), .processor_clock_control_ff(processor_clock_control),
    .core_ff(core_ff), .gpr_wr(cpu_pulse[3]), .gpr_addr(gpr_a), .gpr_wdata(gpr_d),
    .gpr_rdata_ff(gpr_rdata_ff), .gpr_valid_ff(gpr_valid_ff), .pmem_rd_ff(pmem_rd_ff),
    .pmem_addr_ff(pmem_addr_ff), .pmem_rdata(pmem_rdata));
  srs_far_model #(.WORD0(W0), .WORD1(W1)) u_far (
    .pclk(pclk), .pmem_rd_ff(pmem_rd_ff), .pmem_addr_ff(pmem_addr_ff),
    .pmem_rdata(pmem_rdata), .osc_stop_ff(osc_stop_ff), .osc_running(osc_running));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check_val(input logic [63:0] got, input logic [63:0] e, input string what);
    samples_checked++;
    if (got !== e) begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, e);
    end
  endtask
  task automatic check_bus(input logic [33:0] e, input logic err, input logic [31:0] d);
    check_val({err, e[33] ? d : e[31:0]}, e[32:0], "apb");
  endtask
  task automatic wait_sig(input int sel, output int cnt);
    cnt = 0;
    do begin
      @(posedge pclk);
      cnt++;
    end while (ev[sel] !== 1'b1 && cnt < 2000);
    if (cnt >= 2000) begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] ed, input logic ee);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back({!wr, ee, ed});
    @(posedge pclk);
    penable <= 1'b1;
    wait_sig(4, k);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input int b);
    @(posedge pclk);
    cpu_pulse[b] <= 1'b1;
    @(posedge pclk);
    cpu_pulse[b] <= 1'b0;
    @(posedge pclk);
  endtask
  // read and write results leave the queue as pready_ff appears
  always @(posedge pclk) begin
    if (vector_take_ff === 1'b1) vec_cnt <= vec_cnt + 1;
    if (pready_ff === 1'b1 && exp_q.size() > 0) begin
      cur = exp_q.pop_front();
      check_bus(cur, pslverr_ff, prdata_ff);
    end
  end
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, wt_req, ti_req, ti_en, gpr_a, gpr_d} = '0;
    {ext_reset_n, wt_en, irq_req, irq_en, cpu_pulse} = {1'b1, 1'b1, 4'h0, 4'h3, 4'h0};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    wait_sig(0, n);
    check_val(n >= 8, 1, "reset wait");
    check_val(core_ff, {W0[5:0], W1, W0[6], W0[7], 13'h0000}, "core");
    $display("test reset done");
    apb(0, SRS_ADDR_WAIT_SEL, 0, {28'h0, SRS_WAIT_SEL_RST}, 0);
    apb(0, SRS_ADDR_STATUS, 0, {16'h0, SRS_RUN, 4'h1, 4'h0}, 0);
    apb(0, SRS_ADDR_CORE, 0, {3'h0, W0[5:0], W1, W0[6], W0[7], 13'h0000}, 0);
    apb(0, 8'h40, 0, 0, 1);
    r = $random(seed);
    {gpr_d, gpr_a} <= r[22:16];
    apb(1, SRS_ADDR_BANK, r, 0, 0);
    apb(0, SRS_ADDR_BANK, 0, r & 32'h0000FF1F, 0);
    $display("test apb done");
    apb(1, SRS_ADDR_CTRL, 1, 0, 0);
    for (int i = 0; i < 5; i++) begin
      w = waits[i];
      apb(1, SRS_ADDR_WAIT_SEL, {28'h0, i[0], codes[i]}, 0, 0);
      pulse(0);
      check_val({processor_clock_control[3], osc_stop_ff}, 2'b11, "stop entry");
      irq_req[1] <= 1'b1;
      wait_sig(3, n);
      irq_req[1] <= 1'b0;
      wait_sig(0, n);
      check_val(n >= w + 1 && n <= w + 6, 1, "stop wait");
      n = vec_cnt;
      pulse(2);
      check_val(vec_cnt, n, "early vector");
      pulse(2);
      @(posedge pclk);
      check_val(vec_cnt, n + 1, "vector");
    end
    $display("test stop done");
    apb(1, SRS_ADDR_CTRL, 0, 0, 0);
    pulse(1);
    check_val(processor_clock_control[2], 1, "halt entry");
    irq_req[0] <= 1'b1;
    wait_sig(1, n);
    check_val(irq_flag_hold_ff, 1, "flag hold");
    irq_req[0] <= 1'b0;
    apb(1, SRS_ADDR_CTRL, 1, 0, 0);
    n = vec_cnt;
    for (int s = 0; s < 2; s++) begin
      pulse(1);
      if (s == 0) begin
        wt_req <= 1'b1;
      end else begin
        {ti_en, ti_req} <= 2'b11;
      end
      wait_sig(1, w);
      {wt_req, ti_req} <= 2'b00;
      repeat (3) pulse(2);
      check_val(vec_cnt, n, "no vector");
    end
    $display("test halt done");
    pulse(3);
    pulse(1);
    ext_reset_n <= 1'b0;
    repeat (4) @(posedge pclk);
    ext_reset_n <= 1'b1;
    wait_sig(0, n);
    check_val({gpr_valid_ff, gpr_rdata_ff}, {1'b1, gpr_d}, "gpr kept");
    apb(0, SRS_ADDR_BANK, 0, 0, 0);
    apb(0, SRS_ADDR_CTRL, 0, 0, 0);
    $display("test pin reset done");
    finish_test();
  end
endmodule
`default_nettype wire
